//--- design/pbr_regs.svh
// Register offsets, field positions, reset values and frame counts of the PHY basic register bank
`ifndef PBR_REGS_SVH
`define PBR_REGS_SVH

// ==========================================================================
// Management register addresses
`define PBR_ADDR_CTRL        5'h00
`define PBR_ADDR_STAT        5'h01
`define PBR_ADDR_ID_HIGH     5'h02
`define PBR_ADDR_EXT_STAT    5'h0F

// ==========================================================================
// basic_link_control field positions and reset value
`define PBR_CTRL_RATE_LO     13
`define PBR_CTRL_NEG_EN      12
`define PBR_CTRL_PWR_DOWN    11
`define PBR_CTRL_ISOLATE     10
`define PBR_CTRL_RESTART     9
`define PBR_CTRL_DUPLEX      8
`define PBR_CTRL_COL_TEST    7
`define PBR_CTRL_RATE_HI     6
`define PBR_CTRL_RESET       16'h1140

// ==========================================================================
// basic_link_status field positions, fixed ability bits and reset value
`define PBR_STAT_NEG_DONE    5
`define PBR_STAT_REMOTE_FLT  4
`define PBR_STAT_LINK_UP     2
`define PBR_STAT_JABBER      1
`define PBR_STAT_FIXED       16'h7949
`define PBR_STAT_RESET       16'h7949

// ==========================================================================
// Identifier layout: OUI bits 3..18 counted from the MSB as bit 1
`define PBR_OUI_HI_MSB       21
`define PBR_OUI_HI_LSB       6
`define PBR_OUI_DEFAULT      24'h5A3C96

// ==========================================================================
// Management frame layout
`define PBR_OP_READ          2'h2
`define PBR_OP_WRITE         2'h1
`define PBR_HDR_LAST         4'hB
`define PBR_TA_LAST          4'h1
`define PBR_DATA_LAST        4'hF
`define PBR_STRAP_WAIT       2'h2

`endif

//--- design/pbr_pkg.sv
// Types shared by the PHY basic register bank
package pbr_pkg;

    // Management frame receiver states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_HDR,
        ST_TA,
        ST_DATA
    } pbr_state_t;

    // Decoded forced link rate
    typedef enum logic [1:0] {
        RATE_10,
        RATE_100,
        RATE_1000,
        RATE_RSVD
    } pbr_rate_t;

endpackage

//--- design/pbr_sync2.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module pbr_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta  <= '0;
            q_out <= '0;
        end else begin
            meta  <= d_in;
            q_out <= meta;
        end
    end
endmodule

//--- design/pbr_sticky.sv
// Sticky status flags, set by an event and cleared by a read; the set wins
`timescale 1ns/10ps
module pbr_sticky #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] set_in,
    input  wire logic             clr_in,
    output logic      [WIDTH-1:0] flag_out
);
    // Event in the clearing cycle keeps the flag set
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            flag_out <= RESET_VAL;
        end else begin
            flag_out <= set_in | (flag_out & {WIDTH{~clr_in}});
        end
    end
endmodule

//--- design/pbr_phy_basic_regs.sv
// PHY basic control, status and first identifier registers behind the management serial port
`timescale 1ns/10ps
`include "pbr_regs.svh"

module pbr_phy_basic_regs #(
    parameter logic [23:0] OUI = `PBR_OUI_DEFAULT  // Arbitrary neutral value
) (
    input  wire logic              MCLK_IN,
    input  wire logic              SYS_RST_IN,
    input  wire logic              MDC_IN,
    input  wire logic              MDIO_IN,
    output logic                   MDIO_OUT,
    output logic                   MDIO_OE_OUT,
    input  wire logic [4:0]        PHY_ADDR_IN,
    input  wire logic              PWR_DOWN_IN,
    input  wire logic              NEG_DONE_IN,
    input  wire logic              REMOTE_FAULT_IN,
    input  wire logic              JABBER_IN,
    input  wire logic              LINK_UP_IN,
    output logic                   NEG_ENABLE_OUT,
    output logic                   NEG_RESTART_OUT,
    output logic                   ISOLATE_OUT,
    output logic                   FULL_DUPLEX_OUT,
    output logic                   COL_TEST_OUT,
    output pbr_pkg::pbr_rate_t     FORCED_RATE_OUT,
    output logic                   FORCED_RATE_VALID_OUT
);
    import pbr_pkg::*;

    // ======================================================================
    // Pin synchronisers and strap capture
    logic [1:0]  pin_s;
    logic        mdc_s;
    logic        mdio_s;
    logic        mdc_d;
    logic        mdc_rise;
    logic [4:0]  addr_s;
    logic [4:0]  phy_addr;
    logic [1:0]  strap_cnt;
    logic        strap_done;

    pbr_sync2 #(.WIDTH(2)) u_sync_mgmt (
        .clk_in (MCLK_IN),
        .rst_in (SYS_RST_IN),
        .d_in   ({MDC_IN, MDIO_IN}),
        .q_out  (pin_s)
    );

    pbr_sync2 #(.WIDTH(5)) u_sync_addr (
        .clk_in (MCLK_IN),
        .rst_in (SYS_RST_IN),
        .d_in   (PHY_ADDR_IN),
        .q_out  (addr_s)
    );

    assign mdc_s    = pin_s[1];
    assign mdio_s   = pin_s[0];
    assign mdc_rise = mdc_s & ~mdc_d;

    // Clock line edge detector
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            mdc_d <= 1'b0;
        end else begin
            mdc_d <= mdc_s;
        end
    end

    // Station address is caught once the synchroniser has filled after reset
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            strap_cnt  <= 2'h0;
            strap_done <= 1'b0;
            phy_addr   <= 5'h00;
        end else if (!strap_done) begin
            strap_cnt <= strap_cnt + 2'h1;
            if (strap_cnt == `PBR_STRAP_WAIT) begin
                strap_done <= 1'b1;
                phy_addr   <= addr_s;
            end
        end
    end

    // ======================================================================
    // Management frame receiver
    pbr_state_t  state;
    logic [3:0]  cnt;
    logic [11:0] hdr;
    logic [11:0] hdr_next;
    logic [14:0] data_sh;
    logic [15:0] wr_data;
    logic        hit_now;
    logic        rd_hit;
    logic        wr_hit;
    logic [4:0]  reg_addr;
    logic        rd_load;
    logic        wr_strobe;

    assign hdr_next  = {hdr[10:0], mdio_s};
    assign hit_now   = strap_done && (hdr_next[9:5] == phy_addr);
    assign rd_load   = mdc_rise && (state == ST_HDR) && (cnt == `PBR_HDR_LAST)
                       && hit_now && (hdr_next[11:10] == `PBR_OP_READ);
    assign wr_data   = {data_sh, mdio_s};
    assign wr_strobe = mdc_rise && (state == ST_DATA) && (cnt == `PBR_DATA_LAST) && wr_hit;

    // A zero on an idle line opens a frame, so no preamble is needed
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            state    <= ST_IDLE;
            cnt      <= 4'h0;
            hdr      <= 12'h000;
            data_sh  <= 15'h0000;
            rd_hit   <= 1'b0;
            wr_hit   <= 1'b0;
            reg_addr <= 5'h00;
        end else if (mdc_rise) begin
            case (state)
                ST_IDLE: begin
                    cnt <= 4'h0;
                    if (!mdio_s) begin
                        state <= ST_START;
                    end
                end
                ST_START: begin
                    state <= mdio_s ? ST_HDR : ST_IDLE;
                end
                ST_HDR: begin
                    hdr <= hdr_next;
                    cnt <= cnt + 4'h1;
                    if (cnt == `PBR_HDR_LAST) begin
                        state    <= ST_TA;
                        cnt      <= 4'h0;
                        reg_addr <= hdr_next[4:0];
                        rd_hit   <= hit_now && (hdr_next[11:10] == `PBR_OP_READ);
                        wr_hit   <= hit_now && (hdr_next[11:10] == `PBR_OP_WRITE);
                    end
                end
                ST_TA: begin
                    cnt <= cnt + 4'h1;
                    if (cnt == `PBR_TA_LAST) begin
                        state <= ST_DATA;
                        cnt   <= 4'h0;
                    end
                end
                ST_DATA: begin
                    data_sh <= wr_data[14:0];
                    cnt     <= cnt + 4'h1;
                    if (cnt == `PBR_DATA_LAST) begin
                        state  <= ST_IDLE;
                        rd_hit <= 1'b0;
                        wr_hit <= 1'b0;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ======================================================================
    // Control register
    logic        rate_lo;
    logic        restart;
    logic        ctrl_wr;
    localparam logic [15:0] CTRL_RESET = `PBR_CTRL_RESET;  // Reset image, bit-selectable

    assign ctrl_wr = wr_strobe && (reg_addr == `PBR_ADDR_CTRL);

    // Writable control fields; the high rate bit has no flip-flop at all
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            rate_lo         <= CTRL_RESET[`PBR_CTRL_RATE_LO];
            NEG_ENABLE_OUT  <= CTRL_RESET[`PBR_CTRL_NEG_EN];
            ISOLATE_OUT     <= CTRL_RESET[`PBR_CTRL_ISOLATE];
            FULL_DUPLEX_OUT <= CTRL_RESET[`PBR_CTRL_DUPLEX];
            COL_TEST_OUT    <= CTRL_RESET[`PBR_CTRL_COL_TEST];
        end else if (ctrl_wr) begin
            rate_lo         <= wr_data[`PBR_CTRL_RATE_LO];
            NEG_ENABLE_OUT  <= wr_data[`PBR_CTRL_NEG_EN];
            ISOLATE_OUT     <= wr_data[`PBR_CTRL_ISOLATE];
            FULL_DUPLEX_OUT <= wr_data[`PBR_CTRL_DUPLEX];
            COL_TEST_OUT    <= wr_data[`PBR_CTRL_COL_TEST];
        end
    end

    // Restart is a one-cycle request that clears itself
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            restart <= 1'b0;
        end else begin
            restart <= ctrl_wr && wr_data[`PBR_CTRL_RESTART];
        end
    end

    assign NEG_RESTART_OUT       = restart;
    assign FORCED_RATE_VALID_OUT = ~NEG_ENABLE_OUT;

    // Forced rate decode from fixed high bit and writable low bit
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            FORCED_RATE_OUT <= RATE_1000;
        end else begin
            case ({CTRL_RESET[`PBR_CTRL_RATE_HI], rate_lo})
                2'h0:    FORCED_RATE_OUT <= RATE_10;
                2'h1:    FORCED_RATE_OUT <= RATE_100;
                2'h2:    FORCED_RATE_OUT <= RATE_1000;
                default: FORCED_RATE_OUT <= RATE_RSVD;
            endcase
        end
    end

    // ======================================================================
    // Status register
    logic        stat_read;
    logic [2:0]  flags;  // {link down, remote fault, jabber}

    assign stat_read = rd_load && (hdr_next[4:0] == `PBR_ADDR_STAT);

    pbr_sticky #(.WIDTH(3), .RESET_VAL(3'h4)) u_flags (
        .clk_in   (MCLK_IN),
        .rst_in   (SYS_RST_IN),
        .set_in   ({~LINK_UP_IN, REMOTE_FAULT_IN, JABBER_IN}),
        .clr_in   (stat_read),
        .flag_out (flags)
    );

    // ======================================================================
    // Read data selection and serial output
    logic [15:0] ctrl_word;
    logic [15:0] stat_word;
    logic [15:0] rd_word;
    logic [15:0] rd_shift;

    // Register images as seen by a read
    always_comb begin
        ctrl_word = 16'h0000;
        ctrl_word[`PBR_CTRL_RATE_LO]  = rate_lo;
        ctrl_word[`PBR_CTRL_NEG_EN]   = NEG_ENABLE_OUT;
        ctrl_word[`PBR_CTRL_PWR_DOWN] = PWR_DOWN_IN;
        ctrl_word[`PBR_CTRL_ISOLATE]  = ISOLATE_OUT;
        ctrl_word[`PBR_CTRL_RESTART]  = restart;
        ctrl_word[`PBR_CTRL_DUPLEX]   = FULL_DUPLEX_OUT;
        ctrl_word[`PBR_CTRL_COL_TEST] = COL_TEST_OUT;
        ctrl_word[`PBR_CTRL_RATE_HI]  = CTRL_RESET[`PBR_CTRL_RATE_HI];
        stat_word = `PBR_STAT_FIXED;
        stat_word[`PBR_STAT_NEG_DONE]   = NEG_DONE_IN;
        stat_word[`PBR_STAT_REMOTE_FLT] = flags[1];
        stat_word[`PBR_STAT_LINK_UP]    = ~flags[2];
        stat_word[`PBR_STAT_JABBER]     = flags[0];
        case (hdr_next[4:0])
            `PBR_ADDR_CTRL:    rd_word = ctrl_word;
            `PBR_ADDR_STAT:    rd_word = stat_word;
            `PBR_ADDR_ID_HIGH: rd_word = OUI[`PBR_OUI_HI_MSB:`PBR_OUI_HI_LSB];
            default:           rd_word = 16'h0000;
        endcase
    end

    // Turnaround zero then sixteen data bits, each launched after a clock rise
    always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            rd_shift    <= 16'h0000;
            MDIO_OUT    <= 1'b0;
            MDIO_OE_OUT <= 1'b0;
        end else if (rd_load) begin
            rd_shift <= rd_word;
        end else if (mdc_rise && rd_hit) begin
            if (state == ST_TA && cnt == 4'h0) begin
                MDIO_OE_OUT <= 1'b1;
                MDIO_OUT    <= 1'b0;
            end else if (state == ST_DATA && cnt == `PBR_DATA_LAST) begin
                MDIO_OE_OUT <= 1'b0;
                MDIO_OUT    <= 1'b0;
            end else begin
                MDIO_OUT <= rd_shift[15];
                rd_shift <= {rd_shift[14:0], 1'b0};
            end
        end
    end

    // ======================================================================
    // Assertions
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    property p_restart_self_clear;
        NEG_RESTART_OUT |=> !NEG_RESTART_OUT;
    endproperty
    a_restart_self_clear: assert property (p_restart_self_clear) else $error("restart held too long");

    property p_restart_on_write;
        ctrl_wr && wr_data[`PBR_CTRL_RESTART] |=> NEG_RESTART_OUT;
    endproperty
    a_restart_on_write: assert property (p_restart_on_write) else $error("restart not issued");

    property p_ctrl_write;
        ctrl_wr |=> (NEG_ENABLE_OUT == $past(wr_data[`PBR_CTRL_NEG_EN]))
                    && (ISOLATE_OUT == $past(wr_data[`PBR_CTRL_ISOLATE]))
                    && (FULL_DUPLEX_OUT == $past(wr_data[`PBR_CTRL_DUPLEX]))
                    && (COL_TEST_OUT == $past(wr_data[`PBR_CTRL_COL_TEST]));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

    property p_rate_decode;
        ##1 FORCED_RATE_OUT == ($past(rate_lo) ? RATE_RSVD : RATE_1000);
    endproperty
    a_rate_decode: assert property (p_rate_decode) else $error("forced rate wrong");

    property p_fault_sets;
        REMOTE_FAULT_IN && JABBER_IN |=> flags[1] && flags[0];
    endproperty
    a_fault_sets: assert property (p_fault_sets) else $error("event flag missed");

    property p_read_clears;
        stat_read && !JABBER_IN && !REMOTE_FAULT_IN |=> !flags[0] && !flags[1];
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read did not clear");

    property p_link_latch;
        !LINK_UP_IN ##1 (LINK_UP_IN && !stat_read) [*3] |-> flags[2];
    endproperty
    a_link_latch: assert property (p_link_latch) else $error("link drop not held");

    property p_stat_fixed;
        rd_load && hdr_next[4:0] == `PBR_ADDR_STAT |=> (rd_shift & `PBR_STAT_FIXED) == `PBR_STAT_FIXED;
    endproperty
    a_stat_fixed: assert property (p_stat_fixed) else $error("ability bits wrong");

    property p_id_load;
        rd_load && hdr_next[4:0] == `PBR_ADDR_ID_HIGH |=> rd_shift == OUI[`PBR_OUI_HI_MSB:`PBR_OUI_HI_LSB];
    endproperty
    a_id_load: assert property (p_id_load) else $error("identifier wrong");

    property p_no_preamble;
        state == ST_IDLE && mdc_rise && !mdio_s |=> state == ST_START;
    endproperty
    a_no_preamble: assert property (p_no_preamble) else $error("frame start missed");

    c_stat_read: cover property (stat_read);
    c_ctrl_write: cover property (ctrl_wr);
    c_read_drive: cover property (MDIO_OE_OUT && state == ST_DATA);
endmodule

//--- sim/pbr_mdio_master.sv
// Station management controller model that sends management frames
`timescale 1ns/10ps
`include "pbr_regs.svh"
module pbr_mdio_master (
    input  wire logic        clk_in,
    input  wire logic        mdio_in,
    output logic             mdc_out,
    output logic             mdio_out,
    output logic             mdio_oe_out,
    output logic             done_out,
    output logic [15:0]      rd_data_out
);
    // ======================================================================
    // Idle: clock stands low and the line is released
    initial begin
        mdc_out = 1'b0;
        mdio_out = 1'b0;
        mdio_oe_out = 1'b0;
        done_out = 1'b0;
        rd_data_out = 16'h0000;
    end

    // Half of an MDC period, four system clocks
    task automatic half();
        repeat (4) @(posedge clk_in);
        #1;
    endtask

    // Drive one bit while MDC is low, then raise MDC
    task automatic send(input logic b, input logic oe);
        mdc_out = 1'b0;
        mdio_oe_out = oe;
        mdio_out = oe ? b : ~mdio_out;  // Released: the undriven level flips on each bit
        half();
        mdc_out = 1'b1;
    endtask

    // ======================================================================
    // One whole frame; read data is sampled at each MDC rise
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, input logic pre);
        logic [31:0] word;
        logic        rd;
        rd = (op == `PBR_OP_READ);
        word = {2'h1, op, pa, ra, 2'h2, wd};
        if (pre) begin
            for (int i = 0; i < 8; i++) begin
                send(1'b1, 1'b1);
                half();
            end
        end
        for (int i = 31; i >= 0; i--) begin
            send(word[i], !(rd && i < 18));  // Turnaround and data left to the device
            if (rd && i < 16) begin
                rd_data_out[i] = mdio_in;
            end
            half();
        end
        mdc_out = 1'b0;
        mdio_oe_out = 1'b0;  // Line released; the pull-up returns it to idle high
        half();
        done_out = rd;
        @(posedge clk_in);
        #1;
        done_out = 1'b0;
    endtask
endmodule

//--- sim/testbench.sv
// Self-checking bench of the PHY basic register bank
`timescale 1ns/10ps
`include "pbr_regs.svh"
module testbench;
    import pbr_pkg::*;
    localparam logic [23:0] OUI_VAL = 24'hC35A71;  // Arbitrary identifier value
    localparam logic [4:0]  STRAP   = 5'h0B;

    // ======================================================================
    // Bench signals
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        mdc, mdio_m, mdio_m_oe, mdio_d, mdio_d_oe, mdio_wire, done;
    logic        pwr_down, neg_done, fault, jabber, link_up;
    logic        neg_en, restart, isolate, duplex, col_test, rate_valid;
    pbr_rate_t   rate;
    logic [15:0] rd_data, wd, last;
    logic [31:0] rnd;
    int          seed, failures, comparisons, restarts, exp_restarts, cycles;
    string       note_name[$];
    logic [15:0] note_val[$];

    // Clock, wire level with pull-up, and restart pulse counter
    always #12.5 mclk = ~mclk;
    assign mdio_wire = mdio_d_oe ? mdio_d : (mdio_m_oe ? mdio_m : 1'b1);
    always @(posedge mclk) if (restart === 1'b1) restarts++;

    pbr_phy_basic_regs #(.OUI(OUI_VAL)) pbr_phy_basic_regs_inst (
        .MCLK_IN(mclk), .SYS_RST_IN(rst), .MDC_IN(mdc), .MDIO_IN(mdio_wire),
        .MDIO_OUT(mdio_d), .MDIO_OE_OUT(mdio_d_oe), .PHY_ADDR_IN(STRAP),
        .PWR_DOWN_IN(pwr_down), .NEG_DONE_IN(neg_done), .REMOTE_FAULT_IN(fault),
        .JABBER_IN(jabber), .LINK_UP_IN(link_up), .NEG_ENABLE_OUT(neg_en),
        .NEG_RESTART_OUT(restart), .ISOLATE_OUT(isolate), .FULL_DUPLEX_OUT(duplex),
        .COL_TEST_OUT(col_test), .FORCED_RATE_OUT(rate), .FORCED_RATE_VALID_OUT(rate_valid));

    pbr_mdio_master pbr_mdio_master_inst (
        .clk_in(mclk), .mdio_in(mdio_wire), .mdc_out(mdc), .mdio_out(mdio_m),
        .mdio_oe_out(mdio_m_oe), .done_out(done), .rd_data_out(rd_data));

    // ======================================================================
    // Verdict, comparison and driver tasks
    task automatic end_of_test();
        if (failures == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rd(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] exp,
                      input string name, input logic pre);
        note_name.push_back(name);
        note_val.push_back(exp);
        pbr_mdio_master_inst.frame(`PBR_OP_READ, pa, ra, 16'h0000, pre);
    endtask

    task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] v, input logic pre);
        pbr_mdio_master_inst.frame(`PBR_OP_WRITE, pa, ra, v, pre);
    endtask

    task automatic pins(input logic [15:0] v);
        check("ctrl_pins", {9'h0, neg_en, isolate, duplex, col_test, rate, rate_valid},
              {9'h0, v[12], v[10], v[8], v[7], 1'b1, v[13], ~v[12]});
    endtask

    // Watcher: each finished read is compared with the oldest note
    always @(posedge mclk) begin
        if (done === 1'b1 && note_val.size() > 0) begin
            check(note_name.pop_front(), rd_data, note_val.pop_front());
        end
    end

    // Hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end

    // ======================================================================
    // Main sequence
    initial begin
        seed = 45522;
        {pwr_down, neg_done, fault, jabber} = 4'h0;
        link_up = 1'b1;
        repeat (5) @(posedge mclk);
        #1 rst = 1'b0;
        repeat (10) @(posedge mclk);
        #1;
        pins(16'h1140);
        rd(STRAP, `PBR_ADDR_CTRL, 16'h1140, "ctrl_reset", 1'b0);
        rd(STRAP, `PBR_ADDR_STAT, 16'h7949, "stat_latched", 1'b1);
        rd(STRAP, `PBR_ADDR_STAT, 16'h794D, "stat_link", 1'b0);
        rd(STRAP, `PBR_ADDR_ID_HIGH, OUI_VAL[21:6], "id_high", 1'b0);
        // Fault, jabber and a short link drop
        neg_done = 1'b1;
        {fault, jabber, link_up} = 3'h6;
        @(posedge mclk);
        #1 {fault, jabber, link_up} = 3'h1;
        rd(STRAP, `PBR_ADDR_STAT, 16'h797B, "stat_events", 1'b0);
        rd(STRAP, `PBR_ADDR_STAT, 16'h796D, "stat_cleared", 1'b1);
        // Control writes over every rate code and read-only bit
        for (int i = 0; i < 8; i++) begin
            rnd = $random(seed);
            wd = rnd[15:0];
            wd[13] = i[0];
            wd[12] = i[1];
            wd[6] = i[2];
            pwr_down = rnd[16];
            exp_restarts = restarts + wd[9];
            wr(STRAP, `PBR_ADDR_CTRL, wd, i[0]);
            pins(wd);
            check("restart_pulses", restarts[15:0], exp_restarts[15:0]);
            rd(STRAP, `PBR_ADDR_CTRL, (wd & 16'h3580) | 16'h0040 | {4'h0, pwr_down, 11'h0},
               "ctrl_readback", i[1]);
            last = wd;
        end
        // Refused frames
        wr(STRAP ^ 5'h01, `PBR_ADDR_CTRL, ~last, 1'b0);
        pins(last);
        wr(STRAP, `PBR_ADDR_STAT, 16'h0000, 1'b0);
        rd(STRAP, `PBR_ADDR_STAT, 16'h796D, "stat_readonly", 1'b0);
        rd(STRAP, 5'h05, 16'h0000, "unmapped", 1'b0);
        rd(STRAP ^ 5'h01, `PBR_ADDR_CTRL, 16'hFFFF, "other_phy", 1'b0);
        check("pending_reads", 16'(note_val.size()), 16'h0000);
        end_of_test();
    end
endmodule
